/* File: hdl/blc_clamp_ctrl.sv */
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Pin function field selects multipurpose pin meaning
// - Clamp pulse starts restore, averaging, DAC load
// - Internal clamp pulse generated every line
// - External clamp: DACs load on leading edge
// - No clamp pulse: DAC load within 100ms
// - Frequency bit halves crystal clock output
// - Disable bit holds crystal clock output low
// - Start pixel is 13 bits after sync
// - Clamp lasts programmed width, not averaging
// - Clamp width below two gives no clamp
// - Config bit 0 set disables black averaging
// - Averaged pixels per line 16 to 128
// - Loop time constant is 2^(5+field) lines
module blc_clamp_ctrl
  import blc_pkg::*;
#(
  parameter longint UPD_TIMEOUT_CYC = blc_pkg::BLC_UPD_TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic line_sync_input,
  input wire logic clock_invert_input,
  input wire logic gain_offset_written,
  output logic clock_invert_out,
  output logic coast_out,
  output logic external_sample_clock,
  output logic external_sample_clock_sel,
  output logic crystal_clock_output,
  output logic restore_clamp,
  output logic black_start,
  output logic black_window,
  output logic black_loop_tick,
  output logic [3:0] black_loop_exp,
  output logic dac_update
);
  import blc_pkg::*;

  logic [7:0] pll_misc_r;
  logic [7:0] start_hi_r;
  logic [7:0] start_lo_r;
  logic [7:0] clamp_w_r;
  logic [7:0] config_r;
  logic [7:0] ctrl_r;
  logic [1:0] pins_sync;
  logic sync_d_r;
  logic pin_d_r;
  logic [12:0] pix_cnt_r;
  logic [12:0] pix_cnt_nxt;
  logic pix_run_r;
  logic [8:0] evt_cnt_r;
  logic [8:0] evt_cnt_nxt;
  logic evt_run_r;
  logic [11:0] line_cnt_r;
  logic pend_r;
  logic [31:0] tmo_cnt_r;
  logic [1:0] xdiv_r;
  logic clamp_seen_r;

  // Register port decode
  wire wr_misc = reg_wr && (reg_addr == BLC_PLL_MISC_OFS);
  wire wr_hi = reg_wr && (reg_addr == BLC_START_HI_OFS);
  wire wr_lo = reg_wr && (reg_addr == BLC_START_LO_OFS);
  wire wr_w = reg_wr && (reg_addr == BLC_CLAMP_W_OFS);
  wire wr_cfg = reg_wr && (reg_addr == BLC_CONFIG_OFS);
  wire wr_ctrl = reg_wr && (reg_addr == BLC_CTRL_OFS);

  // Field extraction
  wire [1:0] pin_fn = pll_misc_r[BLC_PIN_FN_LO +: 2];
  wire pin_dis = pll_misc_r[BLC_PIN_DIS_BIT];
  wire xclk_half = pll_misc_r[BLC_XCLK_HALF_BIT];
  wire xclk_dis = pll_misc_r[BLC_XCLK_DIS_BIT];
  wire [12:0] start_pix = {start_hi_r[BLC_START_HI_W-1:0], start_lo_r};
  wire auto_en = !config_r[BLC_AUTO_DIS_BIT];
  wire [1:0] avg_sel = config_r[BLC_AVG_SEL_LO +: 2];
  wire [2:0] tc_sel = config_r[BLC_TC_SEL_LO +: 3];
  wire dcr_en = ctrl_r[BLC_DCR_EN_BIT];

  // Pin function decode
  wire fn_clock_invert_input = (pin_fn == BLC_FN_CLOCK_INVERT_INPUT);
  wire fn_clamp = (pin_fn == BLC_FN_CLAMP);
  wire fn_coast = (pin_fn == BLC_FN_COAST);
  wire fn_external_sample_clock = (pin_fn == BLC_FN_EXTERNAL_SAMPLE_CLOCK);
  // Disabled pin reads as forced low whatever its function
  wire pin_lvl = pins_sync[1] && !pin_dis;
  wire sync_lvl = pins_sync[0];

  // Trailing edge of active-high line sync
  wire sync_trail = sync_d_r && !sync_lvl;
  wire ext_lead = fn_clamp && pin_lvl && !pin_d_r;

  // Internal pulse fires when the pixel counter hits the start pixel
  wire int_hit = pix_run_r && (pix_cnt_r == start_pix);
  wire int_clamp = !fn_clamp && int_hit;
  wire clamp_evt = fn_clamp ? ext_lead : int_clamp;

  // Widths measured from the clamp event
  wire [8:0] avg_pixels = BLC_AVG_BASE << avg_sel;
  wire clamp_w_ok = (clamp_w_r >= BLC_CLAMP_MIN_W);
  wire in_clamp = evt_run_r && ({1'b0, clamp_w_r} > evt_cnt_r);
  wire in_avg = evt_run_r && (avg_pixels > evt_cnt_r);
  wire clamp_on = dcr_en && clamp_w_ok && (clamp_evt || in_clamp);
  wire avg_on = auto_en && (clamp_evt || in_avg);

  // Loop length in lines, minus one, from the exponent
  wire [3:0] tc_exp = BLC_TC_BASE_EXP + {1'b0, tc_sel};
  wire [12:0] tc_lines = 13'h0001 << tc_exp;
  wire [11:0] tc_last = 12'(tc_lines - 13'h0001);
  wire loop_wrap = clamp_evt && auto_en && (line_cnt_r == tc_last);

  // Pending DAC load falls back on a timeout without clamp pulses
  wire tmo_done = pend_r && (tmo_cnt_r >= 32'(UPD_TIMEOUT_CYC - 1));
  wire do_update = clamp_evt || tmo_done;

  wire [1:0] xdiv_nxt = xdiv_r + 2'h1;
  wire xclk_lvl = xclk_half ? xdiv_r[1] : xdiv_r[0];

  // Read mux
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      BLC_PLL_MISC_OFS: rd_mux = pll_misc_r;
      BLC_START_HI_OFS: rd_mux = {3'h0, start_hi_r[BLC_START_HI_W-1:0]};
      BLC_START_LO_OFS: rd_mux = start_lo_r;
      BLC_CLAMP_W_OFS: rd_mux = clamp_w_r;
      BLC_CONFIG_OFS: rd_mux = config_r;
      BLC_CTRL_OFS: rd_mux = ctrl_r;
      BLC_STATUS_OFS: rd_mux = {4'h0, clamp_seen_r, pend_r, restore_clamp, black_window};
      default: rd_mux = 8'h00;
    endcase
  end

  // Counter next values saturate so a lost sync cannot wrap
  always_comb begin
    if (sync_trail) begin
      pix_cnt_nxt = 13'h0000;
    end else if (pix_run_r && pix_cnt_r != 13'h1fff) begin
      pix_cnt_nxt = pix_cnt_r + 13'h0001;
    end else begin
      pix_cnt_nxt = pix_cnt_r;
    end
  end

  always_comb begin
    if (clamp_evt) begin
      evt_cnt_nxt = 9'h001;
    end else if (evt_run_r && evt_cnt_r != 9'h1ff) begin
      evt_cnt_nxt = evt_cnt_r + 9'h001;
    end else begin
      evt_cnt_nxt = evt_cnt_r;
    end
  end

  blc_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .async_in({clock_invert_input, line_sync_input}),
    .sync_out(pins_sync)
  );

  // Registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pll_misc_r <= BLC_PLL_MISC_RST;
      start_hi_r <= BLC_START_HI_RST;
      start_lo_r <= BLC_START_LO_RST;
      clamp_w_r <= BLC_CLAMP_W_RST;
      config_r <= BLC_CONFIG_RST;
      ctrl_r <= BLC_CTRL_RST;
    end else if (ce) begin
      if (wr_misc) pll_misc_r <= reg_wdata;
      if (wr_hi) start_hi_r <= {3'h0, reg_wdata[BLC_START_HI_W-1:0]};
      if (wr_lo) start_lo_r <= reg_wdata;
      if (wr_w) clamp_w_r <= reg_wdata;
      if (wr_cfg) config_r <= reg_wdata;
      if (wr_ctrl) ctrl_r <= {7'h00, reg_wdata[BLC_DCR_EN_BIT]};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Line timing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_d_r <= 1'b0;
      pin_d_r <= 1'b0;
      pix_cnt_r <= 13'h0000;
      pix_run_r <= 1'b0;
    end else if (ce) begin
      sync_d_r <= sync_lvl;
      pin_d_r <= pin_lvl;
      pix_cnt_r <= pix_cnt_nxt;
      if (sync_trail) pix_run_r <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      evt_cnt_r <= 9'h000;
      evt_run_r <= 1'b0;
    end else if (ce) begin
      evt_cnt_r <= evt_cnt_nxt;
      if (clamp_evt) evt_run_r <= 1'b1;
    end
  end

  // Clamp and averaging outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      restore_clamp <= 1'b0;
      black_start <= 1'b0;
      black_window <= 1'b0;
    end else if (ce) begin
      restore_clamp <= clamp_on;
      black_start <= clamp_evt && auto_en;
      black_window <= avg_on;
    end
  end

  // Loop time constant line counter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      line_cnt_r <= 12'h000;
      black_loop_tick <= 1'b0;
      black_loop_exp <= 4'h0;
    end else if (ce) begin
      black_loop_exp <= tc_exp;
      black_loop_tick <= loop_wrap;
      if (!auto_en || loop_wrap) begin
        line_cnt_r <= 12'h000;
      end else if (clamp_evt) begin
        line_cnt_r <= line_cnt_r + 12'h001;
      end
    end
  end

  // DAC transfer; a new write during the load cycle stays pending
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      tmo_cnt_r <= 32'h00000000;
      dac_update <= 1'b0;
      clamp_seen_r <= 1'b0;
    end else if (ce) begin
      dac_update <= do_update;
      if (clamp_evt) clamp_seen_r <= 1'b1;
      if (gain_offset_written) begin
        pend_r <= 1'b1;
        tmo_cnt_r <= 32'h00000000;
      end else if (do_update) begin
        pend_r <= 1'b0;
        tmo_cnt_r <= 32'h00000000;
      end else if (pend_r) begin
        tmo_cnt_r <= tmo_cnt_r + 32'h00000001;
      end
    end
  end

  // Multipurpose pin routing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clock_invert_out <= 1'b0;
      coast_out <= 1'b0;
      external_sample_clock <= 1'b0;
      external_sample_clock_sel <= 1'b0;
    end else if (ce) begin
      clock_invert_out <= fn_clock_invert_input && pin_lvl;
      coast_out <= fn_coast && pin_lvl;
      external_sample_clock <= fn_external_sample_clock && pin_lvl;
      external_sample_clock_sel <= fn_external_sample_clock;
    end
  end

  // Crystal clock stand-in: divided from the core clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      xdiv_r <= 2'h0;
      crystal_clock_output <= 1'b0;
    end else if (ce) begin
      xdiv_r <= xdiv_nxt;
      crystal_clock_output <= !xclk_dis && xclk_lvl;
    end
  end
endmodule

/* File: hdl/blc_pkg.sv */
package blc_pkg;
  // Register map, byte offsets on the 8-bit register port
  localparam logic [7:0] BLC_PLL_MISC_OFS = 8'h13;
  localparam logic [7:0] BLC_START_HI_OFS = 8'h14;
  localparam logic [7:0] BLC_START_LO_OFS = 8'h15;
  localparam logic [7:0] BLC_CLAMP_W_OFS = 8'h16;
  localparam logic [7:0] BLC_CONFIG_OFS = 8'h17;
  localparam logic [7:0] BLC_CTRL_OFS = 8'h20;
  localparam logic [7:0] BLC_STATUS_OFS = 8'h21;

  // Reset values
  localparam logic [7:0] BLC_PLL_MISC_RST = 8'h04;
  localparam logic [7:0] BLC_START_HI_RST = 8'h00;
  localparam logic [7:0] BLC_START_LO_RST = 8'h03;
  localparam logic [7:0] BLC_CLAMP_W_RST = 8'h10;
  localparam logic [7:0] BLC_CONFIG_RST = 8'h40;
  localparam logic [7:0] BLC_CTRL_RST = 8'h01;

  // Field positions
  localparam int BLC_PIN_DIS_BIT = 3;
  localparam int BLC_PIN_FN_LO = 4;
  localparam int BLC_XCLK_HALF_BIT = 6;
  localparam int BLC_XCLK_DIS_BIT = 7;
  localparam int BLC_START_HI_W = 5;
  localparam int BLC_AUTO_DIS_BIT = 0;
  localparam int BLC_AVG_SEL_LO = 2;
  localparam int BLC_TC_SEL_LO = 4;
  localparam int BLC_DCR_EN_BIT = 0;

  // Pin function codes
  localparam logic [1:0] BLC_FN_CLOCK_INVERT_INPUT = 2'h0;
  localparam logic [1:0] BLC_FN_CLAMP = 2'h1;
  localparam logic [1:0] BLC_FN_COAST = 2'h2;
  localparam logic [1:0] BLC_FN_EXTERNAL_SAMPLE_CLOCK = 2'h3;

  localparam logic [7:0] BLC_CLAMP_MIN_W = 8'h02;
  localparam logic [3:0] BLC_TC_BASE_EXP = 4'h5;
  localparam logic [8:0] BLC_AVG_BASE = 9'h010;

  // Update timeout when no clamp pulse arrives
  localparam longint BLC_CLK_HZ = 20000000;
  localparam longint BLC_UPD_TIMEOUT_MS = 100;
  localparam longint BLC_UPD_TIMEOUT_CYC = BLC_UPD_TIMEOUT_MS * BLC_CLK_HZ / 1000;
endpackage

/* File: hdl/blc_sync2.sv */
`timescale 1ns/1ps
module blc_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

/* File: tb/black_level_clamp_control_bench.sv */
`timescale 1ns/1ps
module black_level_clamp_control_bench;
  import blc_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pin = 1'b0, gw = 1'b0, run = 1'b0;
  logic hs, ci, co, ec, es, xc, rc, bs, bw, tk, du, p;
  logic [7:0] ad = 8'h00, wd = 8'h00, rdat;
  logic [3:0] le;
  logic [3:0] fx [4] = '{4'h8, 4'h0, 4'h4, 4'h3};
  logic [7:0] cw [4] = '{8'h00, 8'h01, 8'h02, 8'h07};
  int n_fail = 0, checked = 0, dl, wc, ww, nd, nx, nb;
  initial forever #25 clock = ~clock;
  blc_line_source #(.SYNC_W(8), .LINE(400)) i_src (.clock(clock), .run(run), .line_sync_input(hs));
  blc_clamp_ctrl #(.UPD_TIMEOUT_CYC(50)) i_dut (.clock(clock), .rst_n(rst_n), .ce(1'b1), .reg_addr(ad),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .line_sync_input(hs), .clock_invert_input(pin),
    .gain_offset_written(gw), .clock_invert_out(ci), .coast_out(co), .external_sample_clock(ec),
    .external_sample_clock_sel(es), .crystal_clock_output(xc), .restore_clamp(rc), .black_start(bs),
    .black_window(bw), .black_loop_tick(tk), .black_loop_exp(le), .dac_update(du));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    ad <= a;
    wd <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic get(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    rd <= 1'b1;
    ad <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 check("reg_rdata", rdat, e);
  endtask
  // Delay counted in edges from the sync fall, so the pin synchroniser is included
  task automatic line;
    {dl, wc, ww, nd, nb} = 160'h0;
    @(negedge hs);
    for (int k = 1; k < 393; k++) begin
      @(posedge clock);
      #1;
      if (rc === 1'b1 && dl == 0) dl = k;
      wc += (rc === 1'b1);
      ww += (bw === 1'b1);
      nd += (du === 1'b1);
      nb += (bs === 1'b1);
    end
  endtask
  task automatic span(input int n);
    {nd, nx} = 64'h0;
    p = xc;
    repeat (n) begin
      @(posedge clock);
      #1;
      nd += (du === 1'b1);
      nx += (xc !== p);
      p = xc;
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    get(BLC_CONFIG_OFS, 8'h40);
    get(BLC_START_HI_OFS, 8'h00);
    get(BLC_START_LO_OFS, 8'h03);
    get(BLC_CLAMP_W_OFS, 8'h10);
    get(BLC_PLL_MISC_OFS, 8'h04);
    get(BLC_CTRL_OFS, 8'h01);
    get(BLC_STATUS_OFS, 8'h00);
    get(8'h30, 8'h00);
    put(BLC_START_HI_OFS, 8'hff);
    get(BLC_START_HI_OFS, 8'h1f);
    put(BLC_START_HI_OFS, 8'h00);
    put(BLC_START_LO_OFS, 8'h05);
    run <= 1'b1;
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      put(BLC_CONFIG_OFS, 8'h40 + 8'(i * 4));
      put(BLC_CLAMP_W_OFS, cw[i]);
      line();
      check("clamp delay", dl, cw[i] > 1 ? 9 : 0);
      check("clamp width", wc, cw[i] > 1 ? cw[i] : 0);
      check("window", ww, 16 << i);
      check("updates", nd, 1);
      check("starts", nb, 1);
    end
    put(BLC_START_HI_OFS, 8'h01);
    put(BLC_START_LO_OFS, 8'h00);
    repeat (2) begin
      line();
      check("clamp delay", dl, 260);
    end
    put(BLC_START_HI_OFS, 8'h00);
    put(BLC_START_LO_OFS, 8'h05);
    put(BLC_CONFIG_OFS, 8'h41);
    line();
    check("window", ww, 0);
    check("starts", nb, 0);
    check("clamp width", wc, 7);
    put(BLC_CTRL_OFS, 8'h00);
    put(BLC_CONFIG_OFS, 8'h40);
    line();
    check("clamp width", wc, 0);
    check("window", ww, 16);
    check("updates", nd, 1);
    put(BLC_CTRL_OFS, 8'h01);
    get(BLC_STATUS_OFS, 8'h08);
    $display("clamp lines done");
    for (int i = 0; i < 8; i++) begin
      put(BLC_CONFIG_OFS, 8'(i * 16));
      repeat (2) @(posedge clock);
      #1 check("loop exponent", le, 5 + i);
    end
    put(BLC_CONFIG_OFS, 8'h00);
    repeat (2) begin
      {nd, nx} = 64'h0;
      // Step past the edge so the previous tick has dropped
      @(posedge clock);
      #1;
      while (tk !== 1'b1 && nx < 14000) begin
        @(posedge clock);
        #1;
        nd += (du === 1'b1);
        nx++;
      end
      check("loop tick", tk, 1'b1);
    end
    check("lines per tick", nd, 32);
    $display("loop done");
    for (int f = 0; f < 4; f++) begin
      put(BLC_PLL_MISC_OFS, 8'(f * 16));
      pin <= 1'b1;
      repeat (5) @(posedge clock);
      #1 check("pin outputs", {ci, co, ec, es}, fx[f]);
      pin <= 1'b0;
    end
    run <= 1'b0;
    put(BLC_PLL_MISC_OFS, 8'h10);
    span(10);
    pin <= 1'b1;
    span(10);
    check("updates", nd, 1);
    pin <= 1'b0;
    span(10);
    check("updates", nd, 0);
    put(BLC_PLL_MISC_OFS, 8'h00);
    span(20);
    gw <= 1'b1;
    @(posedge clock);
    gw <= 1'b0;
    span(45);
    check("updates", nd, 0);
    span(15);
    check("updates", nd, 1);
    for (int i = 0; i < 3; i++) begin
      put(BLC_PLL_MISC_OFS, 8'(i * 64));
      span(3);
      span(40);
      check("clock toggles", nx, i == 2 ? 0 : 40 >> i);
    end
    check("clock level", xc, 0);
    $display("pins done");
    finish_test();
  end
  // Tests need about 30000 cycles; three times that marks a hang
  initial begin
    #4500000;
    n_fail++;
    finish_test();
  end
endmodule

/* File: tb/blc_clamp_ctrl_properties.sv */
`timescale 1ns/1ps
module blc_clamp_ctrl_properties
  import blc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic crystal_clock_output,
  input wire logic restore_clamp,
  input wire logic black_start,
  input wire logic black_window,
  input wire logic black_loop_tick,
  input wire logic [3:0] black_loop_exp,
  input wire logic dac_update
);
  logic xoff_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Shadow of the output-off bit; assumes the clock enable stays high
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      xoff_r <= 1'b0;
    end else if (reg_wr && reg_addr == BLC_PLL_MISC_OFS) begin
      xoff_r <= reg_wdata[BLC_XCLK_DIS_BIT];
    end
  end
  start_pulse_a: assert property (black_start |=> !black_start) else $error("start too long");
  dac_pulse_a: assert property (dac_update |=> !dac_update) else $error("update too long");
  start_dac_a: assert property (black_start |-> dac_update) else $error("start without update");
  clamp_dac_a: assert property ($rose(restore_clamp) |-> dac_update) else $error("clamp without update");
  clamp_min_a: assert property ($rose(restore_clamp) |=> restore_clamp) else $error("clamp under two");
  win_start_a: assert property ($rose(black_window) |-> black_start) else $error("window without start");
  win_len_a: assert property ($rose(black_window) |-> black_window [*8]) else $error("window too short");
  tick_pulse_a: assert property (black_loop_tick |=> !black_loop_tick) else $error("tick too long");
  tick_start_a: assert property (black_loop_tick |-> black_start) else $error("tick without start");
  exp_range_a: assert property ($past(rst_n) |-> black_loop_exp inside {[4'h5:4'hc]}) else $error("bad exponent");
  xclk_off_a: assert property (xoff_r && $past(xoff_r) |-> !crystal_clock_output) else $error("clock out not low");
endmodule
bind blc_clamp_ctrl blc_clamp_ctrl_properties i_props (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .crystal_clock_output(crystal_clock_output),
  .restore_clamp(restore_clamp), .black_start(black_start), .black_window(black_window),
  .black_loop_tick(black_loop_tick), .black_loop_exp(black_loop_exp), .dac_update(dac_update));

/* File: tb/blc_line_source.sv */
`timescale 1ns/1ps
// Sync pulse heads each line; held low while stopped so no stray trailing edge appears
module blc_line_source #(
  parameter int SYNC_W = 8,
  parameter int LINE = 400
) (
  input wire logic clock,
  input wire logic run,
  output logic line_sync_input
);
  int cnt = 0;
  initial line_sync_input = 1'b0;
  always @(posedge clock) begin
    cnt <= run ? (cnt + 1) % LINE : 0;
    line_sync_input <= run && cnt < SYNC_W;
  end
endmodule
